// ---- src/rps_pkg.sv ----
// Shared constants, register map and carrier types of the resource power sequencer
package rps_pkg;

  // ----------------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------------
  localparam int RPS_NRES_MAX  = 8;
  localparam int RPS_NCORE_MAX = 4;
  localparam int RPS_TW        = 8;
  localparam int RPS_RT_W      = 16;
  localparam int RPS_DIV_W     = 10;
  localparam int RPS_CLK_HZ    = 25_000_000;
  localparam int RPS_LPO_HZ    = 32_768;
  // Whole cycles of clk_i per low_power_clock tick
  localparam int RPS_TICK_DIV  = RPS_CLK_HZ / RPS_LPO_HZ;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RPS_ADR_MIN    = 8'h00;
  localparam logic [7:0] RPS_ADR_RTMR   = 8'h04;
  localparam logic [7:0] RPS_ADR_MODE   = 8'h08;
  localparam logic [7:0] RPS_ADR_STATUS = 8'h0C;
  localparam logic [7:0] RPS_ADR_CMAP   = 8'h10;
  localparam logic [7:0] RPS_ADR_RCFG   = 8'h40;

  // Field positions
  localparam int RPS_RT_CNT_LSB   = 16;
  localparam int RPS_CFG_TOFF_LSB = 8;
  localparam int RPS_CFG_DEP_LSB  = 16;
  localparam int RPS_ST_PEND_LSB  = 8;
  localparam int RPS_ST_PWR_LSB   = 16;
  localparam int RPS_ST_WL_BIT    = 24;
  localparam int RPS_ST_BT_BIT    = 25;

  // Reset values
  localparam logic [7:0] RPS_MIN_RST  = 8'h01;
  localparam logic [7:0] RPS_TON_RST  = 8'h02;
  localparam logic [7:0] RPS_TOFF_RST = 8'h01;

  // Mode request codes
  localparam logic [1:0] RPS_MODE_ACTIVE = 2'h0;
  localparam logic [1:0] RPS_MODE_DOZE   = 2'h1;
  localparam logic [1:0] RPS_MODE_DEEP   = 2'h2;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RPS_PWR_OFF     = 3'b000,
    RPS_PWR_ACTIVE  = 3'b001,
    RPS_PWR_DOZE    = 3'b010,
    RPS_PWR_SAVE    = 3'b011,
    RPS_PWR_DEEP    = 3'b100,
    RPS_PWR_RESTORE = 3'b101
  } rps_pwr_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rps_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rps_wb_rsp_s;

endpackage

// ---- src/rps_sequencer.sv ----
// Resource power sequencer with power-state control and a Wishbone register slave
//
// Behaviour
// - Requests combine core clock requests, minimum mask and active request timer.
// - Each core clock request maps to a programmable resource set first.
// - Every resource is enabled, disabled, transitioning on or transitioning off.
// - A resource timer is zero exactly when the resource is not transitioning.
// - Starting a transition loads enable or disable delay ticks into the timer.
// - Timers count down per low_power_clock tick; zero ends the transition.
// - Zero delay ticks switch the resource immediately without a timed transition.
// - Each tick recomputes the required set through the dependency table.
// - Each tick decrements nonzero timers; zero clears transition flag, inverts on flag.
// - Enabled, unrequested resources without powered dependents start disabling.
// - Disabled, requested resources with all dependencies enabled start enabling.
// - WLAN request high powers regulators and releases WLAN reset; low holds reset.
// - Regulators stay on while either power-on request is high.
// - Doze stops main clocks; only the sequencer keeps its low-power tick.
// - Deep sleep saves state first, restores on interrupt, SDIO resume or timer.
// - Power-down shuts all regulators; only the request pins bring it back.
// - Shutdown disables all outputs and most inputs of the device.
// - Leaving shutdown is a full power-up with no retained state.
`timescale 1ns/1ps

module rps_sequencer #(
  parameter int NRES     = 8,
  parameter int NCORE    = 4,
  parameter int TICK_DIV = rps_pkg::RPS_TICK_DIV
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Register bus
  input  wire rps_pkg::rps_wb_req_s wb_i,
  output rps_pkg::rps_wb_rsp_s      wb_o,
  // Power-on request pins
  input  wire logic                 wlan_power_on_request_i,
  input  wire logic                 bt_power_on_request_i,
  // Requests and wake sources
  input  wire logic [NCORE-1:0]     core_clk_req_i,
  input  wire logic                 ext_irq_i,
  input  wire logic                 sdio_resume_i,
  // Power control
  output logic                      regulator_en_o,
  output logic                      wlan_reset_n_o,
  output logic                      main_clk_en_o,
  output logic                      core_power_en_o,
  output logic                      retention_save_o,
  output logic                      retention_restore_o,
  output logic                      io_enable_o,
  // Resource status
  output logic [NRES-1:0]           resource_on_flag_o,
  output logic [NRES-1:0]           resource_transition_flag_o
);
  import rps_pkg::*;

  // ----------------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------------
  if (NRES < 1 || NRES > RPS_NRES_MAX || NCORE < 1 || NCORE > RPS_NCORE_MAX ||
      TICK_DIV < 2 || TICK_DIV > 1024) begin : g_bad_cfg
    $error("rps_sequencer: unsupported parameter values");
  end

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [NRES-1:0]                on;
    logic [NRES-1:0]                pend;
    logic [NRES-1:0][RPS_TW-1:0]    tmr;
    logic [NRES-1:0][RPS_TW-1:0]    ton;
    logic [NRES-1:0][RPS_TW-1:0]    toff;
    logic [NRES-1:0][NRES-1:0]      dep;
    logic [NRES-1:0]                minm;
    logic [NCORE-1:0][NRES-1:0]     cmap;
    logic [NRES-1:0]                rt_mask;
    logic [RPS_RT_W-1:0]            rt_cnt;
    logic [1:0]                     mode_req;
    logic [RPS_DIV_W-1:0]           div;
    logic                           tick;
    rps_pwr_e                       pwr;
    logic                           ack;
    logic [31:0]                    dat;
    logic                           reg_en;
    logic                           wl_rst_n;
    logic                           main_clk_en;
    logic                           core_pwr_en;
    logic                           save;
    logic                           restore;
    logic                           io_en;
  } rps_state_s;

  rps_state_s      st_q;
  rps_state_s      st_d;
  logic [NRES-1:0] req_c;
  logic [NRES-1:0] need_c;
  logic [NRES-1:0] enabled_c;
  logic            live_c;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function automatic rps_state_s reset_state();
    rps_state_s s;
    s      = '0;
    s.pwr  = RPS_PWR_OFF;
    s.minm = RPS_MIN_RST[NRES-1:0];
    for (int r = 0; r < NRES; r++) begin
      s.ton[r]  = RPS_TON_RST;
      s.toff[r] = RPS_TOFF_RST;
    end
    return s;
  endfunction

  // Pull in everything that a requested resource depends on, transitively
  function automatic logic [NRES-1:0] expand(input logic [NRES-1:0]           r,
                                             input logic [NRES-1:0][NRES-1:0] dep);
    logic [NRES-1:0] acc;
    acc = r;
    for (int k = 0; k < NRES; k++) begin
      for (int s = 0; s < NRES; s++) begin
        if (acc[s]) begin
          acc = acc | dep[s];
        end
      end
    end
    return acc;
  endfunction

  function automatic logic has_dependent(input int                        r,
                                         input logic [NRES-1:0]           powered,
                                         input logic [NRES-1:0][NRES-1:0] dep);
    logic any;
    any = 1'b0;
    for (int s = 0; s < NRES; s++) begin
      if (dep[s][r] && powered[s]) begin
        any = 1'b1;
      end
    end
    return any;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] base, input int n);
    return a[7:2] == 6'(int'(base[7:2]) + n);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------------
  // Request gathering
  // ----------------------------------------------------------------------------
  always_comb begin
    req_c = st_q.minm;
    if (st_q.rt_cnt != '0) begin
      req_c = req_c | st_q.rt_mask;
    end
    for (int c = 0; c < NCORE; c++) begin
      if (core_clk_req_i[c]) begin
        req_c = req_c | st_q.cmap[c];
      end
    end
  end

  assign need_c    = expand(req_c, st_q.dep);
  assign enabled_c = st_q.on & ~st_q.pend;
  assign live_c    = wlan_power_on_request_i || bt_power_on_request_i;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [31:0] rdat;
    logic [31:0] wdat;
    logic        access;
    logic        wake;
    logic        rt_expire;
    rdat      = '0;
    wdat      = '0;
    access    = 1'b0;
    wake      = 1'b0;
    rt_expire = 1'b0;
    st_d      = st_q;

    // Sequencer tick from the fast clock; the divider only stops in reset and power-down, so doze keeps it
    if (st_q.div == RPS_DIV_W'(TICK_DIV - 1)) begin
      st_d.div  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div  = st_q.div + 1'b1;
      st_d.tick = 1'b0;
    end

    if (st_q.tick && st_q.rt_cnt != '0) begin
      st_d.rt_cnt = st_q.rt_cnt - 1'b1;
      rt_expire   = (st_q.rt_cnt == RPS_RT_W'(1));
    end

    // Resource stepping; decisions use the state as it stood before this tick
    if (st_q.tick) begin
      for (int r = 0; r < NRES; r++) begin
        if (st_q.tmr[r] != '0) begin
          st_d.tmr[r] = st_q.tmr[r] - 1'b1;
          if (st_q.tmr[r] == RPS_TW'(1)) begin
            st_d.pend[r] = 1'b0;
            st_d.on[r]   = ~st_q.on[r];
          end
        end else if (!st_q.pend[r]) begin
          if (st_q.on[r] && !need_c[r] &&
              !has_dependent(r, st_q.on | st_q.pend, st_q.dep)) begin
            if (st_q.toff[r] == '0) begin
              st_d.on[r] = 1'b0;
            end else begin
              st_d.pend[r] = 1'b1;
              st_d.tmr[r]  = st_q.toff[r];
            end
          end else if (!st_q.on[r] && need_c[r] &&
                       (st_q.dep[r] & ~enabled_c) == '0) begin
            if (st_q.ton[r] == '0) begin
              st_d.on[r] = 1'b1;
            end else begin
              st_d.pend[r] = 1'b1;
              st_d.tmr[r]  = st_q.ton[r];
            end
          end
        end
      end
    end

    // Power states
    wake = ext_irq_i || sdio_resume_i || rt_expire;
    unique case (st_q.pwr)
      RPS_PWR_OFF: begin
        st_d.pwr = RPS_PWR_ACTIVE;
      end
      RPS_PWR_ACTIVE: begin
        if (st_q.mode_req == RPS_MODE_DEEP) begin
          st_d.pwr = RPS_PWR_SAVE;
        end else if (st_q.mode_req == RPS_MODE_DOZE) begin
          st_d.pwr = RPS_PWR_DOZE;
        end
      end
      RPS_PWR_DOZE: begin
        if (wake || st_q.mode_req == RPS_MODE_ACTIVE) begin
          st_d.pwr      = RPS_PWR_ACTIVE;
          st_d.mode_req = RPS_MODE_ACTIVE;
        end
      end
      RPS_PWR_SAVE: begin
        st_d.pwr = RPS_PWR_DEEP;
      end
      RPS_PWR_DEEP: begin
        if (wake) begin
          st_d.pwr = RPS_PWR_RESTORE;
        end
      end
      RPS_PWR_RESTORE: begin
        st_d.pwr      = RPS_PWR_ACTIVE;
        st_d.mode_req = RPS_MODE_ACTIVE;
      end
      default: begin
        st_d.pwr = RPS_PWR_OFF;
      end
    endcase

    // Register read view; a write merges byte lanes into this view
    access = wb_i.cyc && wb_i.stb && !st_q.ack;
    if (reg_hit(wb_i.adr, RPS_ADR_MIN, 0)) begin
      rdat[NRES-1:0] = st_q.minm;
    end
    if (reg_hit(wb_i.adr, RPS_ADR_RTMR, 0)) begin
      rdat[NRES-1:0]                    = st_q.rt_mask;
      rdat[RPS_RT_CNT_LSB +: RPS_RT_W] = st_q.rt_cnt;
    end
    if (reg_hit(wb_i.adr, RPS_ADR_MODE, 0)) begin
      rdat[1:0] = st_q.mode_req;
    end
    if (reg_hit(wb_i.adr, RPS_ADR_STATUS, 0)) begin
      rdat[NRES-1:0]                = st_q.on;
      rdat[RPS_ST_PEND_LSB +: NRES] = st_q.pend;
      rdat[RPS_ST_PWR_LSB +: 3]     = st_q.pwr;
      rdat[RPS_ST_WL_BIT]           = wlan_power_on_request_i;
      rdat[RPS_ST_BT_BIT]           = bt_power_on_request_i;
    end
    for (int c = 0; c < NCORE; c++) begin
      if (reg_hit(wb_i.adr, RPS_ADR_CMAP, c)) begin
        rdat[NRES-1:0] = st_q.cmap[c];
      end
    end
    for (int r = 0; r < NRES; r++) begin
      if (reg_hit(wb_i.adr, RPS_ADR_RCFG, r)) begin
        rdat[RPS_TW-1:0]                 = st_q.ton[r];
        rdat[RPS_CFG_TOFF_LSB +: RPS_TW] = st_q.toff[r];
        rdat[RPS_CFG_DEP_LSB +: NRES]    = st_q.dep[r];
      end
    end
    wdat     = merge(rdat, wb_i.dat, wb_i.sel);
    st_d.ack = access;
    if (access) begin
      st_d.dat = rdat;
    end
    if (access && wb_i.we) begin
      if (reg_hit(wb_i.adr, RPS_ADR_MIN, 0)) begin
        st_d.minm = wdat[NRES-1:0];
      end
      if (reg_hit(wb_i.adr, RPS_ADR_RTMR, 0)) begin
        st_d.rt_mask = wdat[NRES-1:0];
        st_d.rt_cnt  = wdat[RPS_RT_CNT_LSB +: RPS_RT_W];
      end
      if (reg_hit(wb_i.adr, RPS_ADR_MODE, 0)) begin
        st_d.mode_req = wdat[1:0];
      end
      for (int c = 0; c < NCORE; c++) begin
        if (reg_hit(wb_i.adr, RPS_ADR_CMAP, c)) begin
          st_d.cmap[c] = wdat[NRES-1:0];
        end
      end
      for (int r = 0; r < NRES; r++) begin
        if (reg_hit(wb_i.adr, RPS_ADR_RCFG, r)) begin
          st_d.ton[r]  = wdat[RPS_TW-1:0];
          st_d.toff[r] = wdat[RPS_CFG_TOFF_LSB +: RPS_TW];
          st_d.dep[r]  = wdat[RPS_CFG_DEP_LSB +: NRES];
        end
      end
    end

    // Pin-driven controls and domain enables
    st_d.reg_en      = live_c;
    st_d.wl_rst_n    = wlan_power_on_request_i;
    st_d.io_en       = 1'b1;
    st_d.main_clk_en = st_d.pwr inside {RPS_PWR_ACTIVE, RPS_PWR_SAVE, RPS_PWR_RESTORE};
    st_d.core_pwr_en = st_d.pwr != RPS_PWR_DEEP;
    st_d.save        = st_d.pwr == RPS_PWR_SAVE;
    st_d.restore     = st_d.pwr == RPS_PWR_RESTORE;

    // Both pins low is power-down: everything returns to its power-up value
    if (rst_i || !live_c) begin
      st_d = reset_state();
    end
  end

  always_ff @(posedge clk_i) begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign wb_o.ack                   = st_q.ack;
  assign wb_o.dat                   = st_q.dat;
  assign regulator_en_o             = st_q.reg_en;
  assign wlan_reset_n_o             = st_q.wl_rst_n;
  assign main_clk_en_o              = st_q.main_clk_en;
  assign core_power_en_o            = st_q.core_pwr_en;
  assign retention_save_o           = st_q.save;
  assign retention_restore_o        = st_q.restore;
  assign io_enable_o                = st_q.io_en;
  assign resource_on_flag_o         = st_q.on;
  assign resource_transition_flag_o = st_q.pend;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  for (genvar r = 0; r < NRES; r++) begin : g_res_chk
    a_timer_zero_idle: assert property ((st_q.tmr[r] != '0) == st_q.pend[r])
      else $error("transition flag and timer disagree");
    // A pin drop in the deciding cycle resets the state, so the pins count in that cycle
    a_timer_count_down: assert property (live_c && st_q.tick && st_q.tmr[r] > RPS_TW'(1)
      |=> st_q.tmr[r] == $past(st_q.tmr[r]) - 1'b1 && st_q.pend[r])
      else $error("timer did not step down by one");
    a_timer_done_flip: assert property (live_c && st_q.tick && st_q.tmr[r] == RPS_TW'(1)
      |=> !st_q.pend[r] && st_q.on[r] != $past(st_q.on[r]))
      else $error("expired timer did not end the transition");
    a_start_enable: assert property (live_c && st_q.tick && !st_q.on[r] && !st_q.pend[r]
      && need_c[r] && (st_q.dep[r] & ~enabled_c) == '0
      |=> ($past(st_q.ton[r]) == '0) ? (st_q.on[r] && !st_q.pend[r])
                                      : (st_q.pend[r] && st_q.tmr[r] == $past(st_q.ton[r])))
      else $error("enable sequence not started correctly");
    a_start_disable: assert property (live_c && st_q.tick && st_q.on[r] && !st_q.pend[r]
      && !need_c[r] && !has_dependent(r, st_q.on | st_q.pend, st_q.dep)
      |=> ($past(st_q.toff[r]) == '0) ? !st_q.on[r]
                                       : (st_q.pend[r] && st_q.tmr[r] == $past(st_q.toff[r])))
      else $error("disable sequence not started correctly");
  end

  a_regulator_or: assert property (!$past(rst_i) |->
    regulator_en_o == $past(live_c) && wlan_reset_n_o == $past(wlan_power_on_request_i))
    else $error("regulator or WLAN reset output does not follow the pins");
  a_doze_clocks: assert property (st_q.pwr == RPS_PWR_DOZE |->
    !main_clk_en_o && core_power_en_o)
    else $error("doze mode clock or power control wrong");
  a_save_first: assert property ($rose(st_q.pwr == RPS_PWR_DEEP) |->
    $past(retention_save_o) && $past(core_power_en_o) && !core_power_en_o)
    else $error("deep sleep entered without saving state");
  a_deep_wake: assert property (live_c && st_q.pwr == RPS_PWR_DEEP &&
    (ext_irq_i || sdio_resume_i) ##1 live_c |->
    retention_restore_o ##1 st_q.pwr == RPS_PWR_ACTIVE)
    else $error("wake from deep sleep did not restore");
  a_shutdown_clear: assert property (!live_c |=> !regulator_en_o && !io_enable_o &&
    st_q.on == '0 && st_q.pend == '0 && st_q.minm == RPS_MIN_RST[NRES-1:0])
    else $error("power-down did not clear the device");

  c_deep_cycle: cover property (st_q.pwr == RPS_PWR_SAVE ##1 st_q.pwr == RPS_PWR_DEEP
    ##[1:1000] st_q.pwr == RPS_PWR_RESTORE);
  c_doze_entry: cover property ($rose(st_q.pwr == RPS_PWR_DOZE));
  c_timed_enable: cover property (st_q.pend[0] && !st_q.on[0] ##1 st_q.on[0] && !st_q.pend[0]);
  c_power_down: cover property (live_c ##1 !live_c);

endmodule

// ---- sim/rps_host_model.sv ----
// Host model that drives the two power-on request pins of the sequencer
`timescale 1ns/1ps

module rps_host_model (
  // Clock and wanted pin levels from the bench
  input  wire logic       clk_i,
  input  wire logic [1:0] want_i,
  // Power-on request pins
  output logic            wlan_power_on_request_o = 1'b0,
  output logic            bt_power_on_request_o   = 1'b0
);
  // Pins move just after an edge; both low is the only way into power-down
  always @(posedge clk_i) begin
    wlan_power_on_request_o <= want_i[1];
    bt_power_on_request_o   <= want_i[0];
  end
endmodule

// ---- sim/rps_sequencer_tb.sv ----
// Self-checking bench of the resource power sequencer
`timescale 1ns/1ps

module rps_sequencer_tb;
  import rps_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  rps_wb_req_s wb_i  = '0;
  rps_wb_rsp_s wb_o;
  logic [1:0]  want  = 2'b11;
  logic [3:0]  creq  = 4'h0;
  logic        irq   = 1'b0;
  logic        sdio  = 1'b0;
  logic        wl, bt, reg_en, wl_rst_n, mclk, cpwr, rsave, rrest, io_en;
  logic [7:0]  on_f, tr_f;
  logic [31:0] rd;
  logic [15:0] lfsr  = 16'hD79D;
  int          n_fail = 0;
  int          check_count = 0;

  // ------------------------------------------------------------------
  // Clock, partner and design
  // ------------------------------------------------------------------
  initial forever #20 clk_i = ~clk_i;

  rps_host_model host (.clk_i(clk_i), .want_i(want), .wlan_power_on_request_o(wl),
                       .bt_power_on_request_o(bt));

  rps_sequencer #(.TICK_DIV(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .wlan_power_on_request_i(wl), .bt_power_on_request_i(bt), .core_clk_req_i(creq),
    .ext_irq_i(irq), .sdio_resume_i(sdio), .regulator_en_o(reg_en),
    .wlan_reset_n_o(wl_rst_n), .main_clk_en_o(mclk), .core_power_en_o(cpwr),
    .retention_save_o(rsave), .retention_restore_o(rrest), .io_enable_o(io_en),
    .resource_on_flag_o(on_f), .resource_transition_flag_o(tr_f));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [1:0] pin_exp(input logic [1:0] w);
    return {w[1] | w[0], w[1]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    @(posedge clk_i);
    while (wb_o.ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) n_fail++;
    rd = wb_o.dat;
    wb_i.cyc <= 1'b0;
    wb_i.stb <= 1'b0;
  endtask

  // Waits for a settled flag; a stuck timer shows up as a mismatch
  task automatic wait_on(input int b, input logic v);
    int n;
    n = 0;
    while ((on_f[b] !== v || tr_f[b] !== 1'b0) && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    check("resource on flag", {31'h0, on_f[b]}, {31'h0, v});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    #(40 * 30000);
    n_fail++;
    print_verdict();
  end

  initial begin
    logic seen;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, RPS_ADR_MIN, 32'h0);
    check("min mask reset", rd, {24'h0, RPS_MIN_RST});
    wb(1'b0, RPS_ADR_RCFG, 32'h0);
    check("config reset", rd, {16'h0, RPS_TOFF_RST, RPS_TON_RST});
    wb(1'b0, 8'h3C, 32'h0);
    check("unmapped read", rd, 32'h0);
    wait_on(0, 1'b1);
    wb(1'b1, RPS_ADR_RCFG + 8'h04, 32'h0);
    wb(1'b1, RPS_ADR_MIN, 32'h03);
    wait_on(1, 1'b1);
    lfsr = nxt(lfsr);
    wb(1'b1, RPS_ADR_RCFG + 8'h10, {16'h0, RPS_TOFF_RST, 4'h0, lfsr[3:0] | 4'h1});
    wb(1'b1, RPS_ADR_RCFG + 8'h0C, 32'h0010_0101);
    wb(1'b1, RPS_ADR_MIN, 32'h0B);
    wait_on(4, 1'b1);
    wait_on(3, 1'b1);
    check("transition flags idle", {24'h0, tr_f}, 32'h0);
    wb(1'b1, RPS_ADR_CMAP, 32'h04);
    creq <= lfsr[7:4] | 4'h1;
    wait_on(2, 1'b1);
    creq <= 4'h0;
    wait_on(2, 1'b0);
    wb(1'b1, RPS_ADR_MIN, 32'h01);
    wait_on(3, 1'b0);
    wait_on(4, 1'b0);
    // Request timer alone asks for resource 2 until its count runs out
    wb(1'b1, RPS_ADR_RTMR, {16'h0020, 16'h0004});
    wait_on(2, 1'b1);
    wait_on(2, 1'b0);
    wb(1'b1, RPS_ADR_MODE, {30'h0, RPS_MODE_DOZE});
    repeat (3) @(posedge clk_i);
    check("main clock in doze", {31'h0, mclk}, 32'h0);
    irq <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("main clock after wake", {31'h0, mclk}, 32'h1);
    irq <= 1'b0;
    wb(1'b1, RPS_ADR_MODE, {30'h0, RPS_MODE_DEEP});
    seen = 1'b0;
    repeat (6) @(posedge clk_i) seen |= rsave;
    check("save then core off", {30'h0, seen, cpwr}, 32'h2);
    sdio <= 1'b1;
    seen = 1'b0;
    repeat (6) @(posedge clk_i) seen |= rrest;
    sdio <= 1'b0;
    check("restore then core on", {30'h0, seen, cpwr}, 32'h3);
    // Leave a non-reset minimum mask so that power-down has something to clear
    wb(1'b1, RPS_ADR_MIN, 32'h21);
    for (int i = 3; i >= 0; i--) begin
      want <= i[1:0];
      repeat (4) @(posedge clk_i);
      check("pin controls", {30'h0, reg_en, wl_rst_n}, {30'h0, pin_exp(i[1:0])});
    end
    check("io disabled in shutdown", {31'h0, io_en}, 32'h0);
    want <= 2'b01;
    repeat (4) @(posedge clk_i);
    wb(1'b0, RPS_ADR_MIN, 32'h0);
    check("min mask after power-up", rd, {24'h0, RPS_MIN_RST});
    wb(1'b0, RPS_ADR_CMAP, 32'h0);
    check("core map after power-up", rd, 32'h0);
    print_verdict();
  end
endmodule
